// ---- rst_init_pkg.sv ----
package rst_init_pkg;
  // ==========================================
  // widths and types
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int NIB_W = 4;
  localparam int BSC_N = 4;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] data_t;
  typedef logic [PC_W-1:0] pc_t;
  typedef logic [NIB_W-1:0] nib_t;
  // ==========================================
  // reset vector layout in program memory
  localparam pc_t VEC_ADDR_HI = 13'h0000;
  localparam pc_t VEC_ADDR_LO = 13'h0001;
  localparam int VEC_PCH_MSB = 4;
  localparam int VEC_ERB_BIT = 6;
  localparam int VEC_EMB_BIT = 7;
  // ==========================================
  // data ram: lost window on every reset
  localparam logic [7:0] ERASE_FIRST = 8'hf8;
  localparam logic [7:0] ERASE_LAST = 8'hfd;
  localparam logic [7:0] WORK_LAST = 8'h07;
  localparam logic [3:0] ERASE_LEN = 4'h6;
  // ==========================================
  // register map, addr bit 8 selects the data ram
  localparam int RAM_SEL_BIT = 8;
  localparam addr_t OFS_PWR_CTRL = 9'h000;
  localparam addr_t OFS_SUBSTOP = 9'h001;
  localparam addr_t OFS_CLK_OUT = 9'h002;
  localparam addr_t OFS_SYS_CLK = 9'h003;
  localparam addr_t OFS_MEM_BANK = 9'h004;
  localparam addr_t OFS_REG_BANK = 9'h005;
  localparam addr_t OFS_FLAGS = 9'h006;
  localparam addr_t OFS_PC_HI = 9'h007;
  localparam addr_t OFS_PC_LO = 9'h008;
  localparam addr_t OFS_STATUS = 9'h009;
  localparam addr_t OFS_STACK = 9'h00a;
  localparam addr_t OFS_BSC0 = 9'h00c;
  // flags register fields
  localparam int FLG_IS_LOW = 0;
  localparam int FLG_IS_HIGH = 1;
  localparam int FLG_ERB = 2;
  localparam int FLG_EMB = 3;
  localparam nib_t NIB_RST = 4'h0;
  localparam data_t DATA_ZERO = 8'h00;
  // ==========================================
  // sequencer states
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_CLEAR = 2'b01,
    ST_FETCH = 2'b10,
    ST_RUN = 2'b11
  } seq_state_e;
  typedef enum logic [1:0] {
    VL_IDLE = 2'b00,
    VL_A0 = 2'b01,
    VL_A1 = 2'b10,
    VL_DONE = 2'b11
  } vec_state_e;
endpackage

// ---- rst_init_if.sv ----
`timescale 1ns/1ps
interface ram_if;
  logic [7:0] addr;
  logic [3:0] wdata;
  logic [3:0] rdata;
  logic we;
  logic erase_start;
  logic erase_busy;
  modport ctl(output addr, output wdata, output we, output erase_start, input rdata, input erase_busy);
  modport mem(input addr, input wdata, input we, input erase_start, output rdata, output erase_busy);
endinterface

interface vec_if;
  logic start;
  logic done;
  logic register_bank_enable_flag;
  logic memory_bank_enable_flag;
  logic [12:0] pc;
  modport ctl(output start, input done, input register_bank_enable_flag, input memory_bank_enable_flag, input pc);
  modport ldr(input start, output done, output register_bank_enable_flag, output memory_bank_enable_flag, output pc);
endinterface

// ---- gp_ram.sv ----
`timescale 1ns/1ps
module gp_ram (
  input wire logic clk,
  input wire logic rst_n,
  ram_if.mem r
);
  import rst_init_pkg::*;

  // no reset on the array: contents outside f8..fd survive a pin reset, undefined at power-on
  nib_t mem [0:255];
  logic busy_q, busy_d;
  logic [7:0] ptr_q, ptr_d;
  logic wen;
  logic [7:0] wadr;
  nib_t wdat;

  // ==========================================
  // erase walk and write port
  always_comb begin
    busy_d = busy_q;
    ptr_d = ptr_q;
    wen = r.we;
    wadr = r.addr;
    wdat = r.wdata;
    if (r.erase_start) begin
      busy_d = 1'b1;
      ptr_d = ERASE_FIRST;
    end else if (busy_q) begin
      wen = 1'b1;
      wadr = ptr_q;
      wdat = NIB_RST;
      ptr_d = ptr_q + 8'h01;
      if (ptr_q == ERASE_LAST) begin
        busy_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      ptr_q <= ERASE_FIRST;
    end else begin
      busy_q <= busy_d;
      ptr_q <= ptr_d;
    end
  end

  // only written cells change, working registers included
  always_ff @(posedge clk) begin
    if (wen) begin
      mem[wadr] <= wdat;
    end
  end

  assign r.rdata = mem[r.addr];
  assign r.erase_busy = busy_q;

  // ==========================================
  // checks
  logic [31:0] work_h;
  logic [23:0] lost_h;
  assign work_h = {mem[7], mem[6], mem[5], mem[4], mem[3], mem[2], mem[1], mem[0]};
  assign lost_h = {mem[8'hfd], mem[8'hfc], mem[8'hfb], mem[8'hfa], mem[8'hf9], mem[8'hf8]};

  sequence s_walk;
    busy_q [*6] ##1 !busy_q;
  endsequence
  property p_erase;
    @(posedge clk) disable iff (!rst_n) r.erase_start |=> s_walk ##0 (lost_h == 24'h000000);
  endproperty
  a_erase: assert property (p_erase) else $error("reset window not cleared in six cycles");

  property p_keep_work;
    @(posedge clk) disable iff (!rst_n) !(wen && wadr <= WORK_LAST) |=> $stable(work_h);
  endproperty
  a_keep_work: assert property (p_keep_work) else $error("working register changed without a write");
endmodule

// ---- vec_loader.sv ----
`timescale 1ns/1ps
module vec_loader (
  input wire logic clk,
  input wire logic rst_n,
  vec_if.ldr v,
  output logic [12:0] pmem_addr,
  output logic pmem_rd,
  input wire logic [7:0] pmem_data
);
  import rst_init_pkg::*;

  vec_state_e st_q, st_d;
  pc_t addr_q, addr_d, pc_q, pc_d;
  logic rd_q, rd_d, done_q, done_d, erb_q, erb_d, emb_q, emb_d;
  data_t b0_q, b0_d;

  // ==========================================
  // two-byte vector fetch, rom answers one cycle after the read
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    rd_d = 1'b0;
    done_d = 1'b0;
    b0_d = b0_q;
    pc_d = pc_q;
    erb_d = erb_q;
    emb_d = emb_q;
    case (st_q)
      VL_IDLE: begin
        if (v.start) begin
          st_d = VL_A0;
          addr_d = VEC_ADDR_HI;
          rd_d = 1'b1;
        end
      end
      VL_A0: begin
        st_d = VL_A1;
        addr_d = VEC_ADDR_LO;
        rd_d = 1'b1;
      end
      VL_A1: begin
        st_d = VL_DONE;
        b0_d = pmem_data;
      end
      VL_DONE: begin
        st_d = VL_IDLE;
        pc_d = {b0_q[VEC_PCH_MSB:0], pmem_data};
        erb_d = b0_q[VEC_ERB_BIT];
        emb_d = b0_q[VEC_EMB_BIT];
        done_d = 1'b1;
      end
      default: st_d = VL_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= VL_IDLE;
      addr_q <= VEC_ADDR_HI;
      rd_q <= 1'b0;
      done_q <= 1'b0;
      b0_q <= DATA_ZERO;
      pc_q <= VEC_ADDR_HI;
      erb_q <= 1'b0;
      emb_q <= 1'b0;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      done_q <= done_d;
      b0_q <= b0_d;
      pc_q <= pc_d;
      erb_q <= erb_d;
      emb_q <= emb_d;
    end
  end

  assign pmem_addr = addr_q;
  assign pmem_rd = rd_q;
  assign v.pc = pc_q;
  assign v.done = done_q;
  assign v.register_bank_enable_flag = erb_q;
  assign v.memory_bank_enable_flag = emb_q;

  // ==========================================
  // checks
  logic [4:0] pch_h;
  logic erb_h, emb_h;
  assign pch_h = pmem_data[4:0];
  assign erb_h = pmem_data[6];
  assign emb_h = pmem_data[7];

  sequence s_fetch;
    (rd_q && addr_q == 13'h0000) ##1 (rd_q && addr_q == 13'h0001) ##1 !rd_q ##1 done_q;
  endsequence
  property p_vec_seq;
    @(posedge clk) disable iff (!rst_n) (v.start && st_q == VL_IDLE) |=> s_fetch;
  endproperty
  a_vec_seq: assert property (p_vec_seq) else $error("vector fetch sequence wrong");

  property p_pc_hi;
    @(posedge clk) disable iff (!rst_n) done_q |-> pc_q[12:8] == $past(pch_h, 2);
  endproperty
  a_pc_hi: assert property (p_pc_hi) else $error("pc high bits not from byte 0");

  property p_pc_lo;
    @(posedge clk) disable iff (!rst_n) done_q |-> pc_q[7:0] == $past(pmem_data, 1);
  endproperty
  a_pc_lo: assert property (p_pc_lo) else $error("pc low byte not from byte 1");

  property p_bank_en;
    @(posedge clk) disable iff (!rst_n) done_q |-> (erb_q == $past(erb_h, 2)) && (emb_q == $past(emb_h, 2));
  endproperty
  a_bank_en: assert property (p_bank_en) else $error("bank enable flags not from byte 0");
endmodule

// ---- cpu_reset_init.sv ----
// Functional notes
// - pc 12..8 from low bits of byte 0000
// - pc 7..0 from byte 0001
// - byte 0000 bit6 register bank enable, bit7 memory
// - clear bank selects and four carrier registers
// - clear both interrupt status flags
// - keep working registers on operating reset
// - keep ram except lost window f8..fd
// - clear power control register
// - clear subclock stop control
// - clear clock output mode register
// - clear system clock mode register
// - chip enable rising edge also resets
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
module cpu_reset_init (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic RESET_PIN_N,
  input wire logic CE_PIN,
  input wire rst_init_pkg::addr_t ADDR,
  input wire rst_init_pkg::data_t WDATA,
  input wire logic WR,
  input wire logic RD,
  output rst_init_pkg::data_t RDATA,
  output rst_init_pkg::pc_t PMEM_ADDR,
  output logic PMEM_RD,
  input wire rst_init_pkg::data_t PMEM_DATA,
  output rst_init_pkg::pc_t PROGRAM_COUNTER,
  output logic CPU_RUN
);
  import rst_init_pkg::*;

  // ==========================================
  // reset release and pin synchronisers
  logic rst_s1_q, rst_n;
  logic pin_s1_q, pin_s2_q, ce_s1_q, ce_s2_q, ce_prev_q;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // pin reads as asserted until sampled, so power-on walks the same path
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      ce_s1_q <= 1'b0;
      ce_s2_q <= 1'b0;
      ce_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= RESET_PIN_N;
      pin_s2_q <= pin_s1_q;
      ce_s1_q <= CE_PIN;
      ce_s2_q <= ce_s1_q;
      ce_prev_q <= ce_s2_q;
    end
  end

  logic pin_rst, ce_rise;
  assign pin_rst = !pin_s2_q;
  assign ce_rise = ce_s2_q && !ce_prev_q;

  // ==========================================
  // submodules
  ram_if ram ();
  vec_if vec ();

  gp_ram u_ram (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .r(ram.mem)
  );

  vec_loader u_vec (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .v(vec.ldr),
    .pmem_addr(PMEM_ADDR),
    .pmem_rd(PMEM_RD),
    .pmem_data(PMEM_DATA)
  );

  // ==========================================
  // reset sequencer
  seq_state_e st_q, st_d;
  logic erase_q, erase_d, vstart_q, vstart_d, run_q, run_d;

  always_comb begin
    st_d = st_q;
    erase_d = 1'b0;
    vstart_d = 1'b0;
    if (pin_rst || ce_rise) begin
      st_d = ST_HOLD;
    end else begin
      case (st_q)
        ST_HOLD: begin
          st_d = ST_CLEAR;
          erase_d = 1'b1;
        end
        ST_CLEAR: begin
          if (!erase_q && !ram.erase_busy) begin
            st_d = ST_FETCH;
            vstart_d = 1'b1;
          end
        end
        ST_FETCH: begin
          if (vec.done) begin
            st_d = ST_RUN;
          end
        end
        ST_RUN: st_d = ST_RUN;
        default: st_d = ST_HOLD;
      endcase
    end
    run_d = (st_d == ST_RUN);
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_HOLD;
      erase_q <= 1'b0;
      vstart_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      st_q <= st_d;
      erase_q <= erase_d;
      vstart_q <= vstart_d;
      run_q <= run_d;
    end
  end

  assign vec.start = vstart_q;
  assign ram.erase_start = erase_q;

  // ==========================================
  // cpu state registers
  nib_t pwr_q, pwr_d, sstp_q, sstp_d, clko_q, clko_d, sclk_q, sclk_d;
  nib_t mbank_q, mbank_d, rbank_q, rbank_d;
  nib_t bsc_q [BSC_N], bsc_d [BSC_N];
  logic is_lo_q, is_lo_d, is_hi_q, is_hi_d, erb_q, erb_d, emb_q, emb_d;
  data_t sp_q, sp_d;
  logic wr_ok;
  assign wr_ok = WR && run_q && !ADDR[RAM_SEL_BIT];

  always_comb begin
    pwr_d = pwr_q;
    sstp_d = sstp_q;
    clko_d = clko_q;
    sclk_d = sclk_q;
    mbank_d = mbank_q;
    rbank_d = rbank_q;
    bsc_d = bsc_q;
    is_lo_d = is_lo_q;
    is_hi_d = is_hi_q;
    erb_d = erb_q;
    emb_d = emb_q;
    sp_d = sp_q;
    if (st_q == ST_HOLD) begin
      pwr_d = NIB_RST;
      sstp_d = NIB_RST;
      clko_d = NIB_RST;
      sclk_d = NIB_RST;
      mbank_d = NIB_RST;
      rbank_d = NIB_RST;
      for (int i = 0; i < BSC_N; i++) begin
        bsc_d[i] = NIB_RST;
      end
      is_lo_d = 1'b0;
      is_hi_d = 1'b0;
    end else if (vec.done && st_q == ST_FETCH) begin
      erb_d = vec.register_bank_enable_flag;
      emb_d = vec.memory_bank_enable_flag;
    end else if (wr_ok) begin
      case (ADDR)
        OFS_PWR_CTRL: pwr_d = WDATA[3:0];
        OFS_SUBSTOP: sstp_d = WDATA[3:0];
        OFS_CLK_OUT: clko_d = WDATA[3:0];
        OFS_SYS_CLK: sclk_d = WDATA[3:0];
        OFS_MEM_BANK: mbank_d = WDATA[3:0];
        OFS_REG_BANK: rbank_d = WDATA[3:0];
        OFS_FLAGS: begin
          is_lo_d = WDATA[FLG_IS_LOW];
          is_hi_d = WDATA[FLG_IS_HIGH];
          erb_d = WDATA[FLG_ERB];
          emb_d = WDATA[FLG_EMB];
        end
        OFS_STACK: sp_d = WDATA;
        default: begin
          if (ADDR >= OFS_BSC0 && ADDR < OFS_BSC0 + 9'(BSC_N)) begin
            bsc_d[ADDR[1:0]] = WDATA[3:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q <= NIB_RST;
      sstp_q <= NIB_RST;
      clko_q <= NIB_RST;
      sclk_q <= NIB_RST;
      mbank_q <= NIB_RST;
      rbank_q <= NIB_RST;
      for (int i = 0; i < BSC_N; i++) begin
        bsc_q[i] <= NIB_RST;
      end
      is_lo_q <= 1'b0;
      is_hi_q <= 1'b0;
      erb_q <= 1'b0;
      emb_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      sstp_q <= sstp_d;
      clko_q <= clko_d;
      sclk_q <= sclk_d;
      mbank_q <= mbank_d;
      rbank_q <= rbank_d;
      bsc_q <= bsc_d;
      is_lo_q <= is_lo_d;
      is_hi_q <= is_hi_d;
      erb_q <= erb_d;
      emb_q <= emb_d;
    end
  end

  // software owns the stack pointer; reset deliberately leaves it alone
  always_ff @(posedge REF_CLK) begin
    sp_q <= sp_d;
  end

  // ==========================================
  // data ram port: blocked until the vector is loaded
  assign ram.addr = ADDR[7:0];
  assign ram.wdata = WDATA[3:0];
  assign ram.we = WR && run_q && ADDR[RAM_SEL_BIT] && !ram.erase_busy;

  // ==========================================
  // read data, one cycle after the strobe
  data_t rdata_q, rdata_d;

  always_comb begin
    rdata_d = DATA_ZERO;
    if (RD) begin
      if (ADDR[RAM_SEL_BIT]) begin
        rdata_d = {4'h0, ram.rdata};
      end else begin
        case (ADDR)
          OFS_PWR_CTRL: rdata_d = {4'h0, pwr_q};
          OFS_SUBSTOP: rdata_d = {4'h0, sstp_q};
          OFS_CLK_OUT: rdata_d = {4'h0, clko_q};
          OFS_SYS_CLK: rdata_d = {4'h0, sclk_q};
          OFS_MEM_BANK: rdata_d = {4'h0, mbank_q};
          OFS_REG_BANK: rdata_d = {4'h0, rbank_q};
          OFS_FLAGS: rdata_d = {4'h0, emb_q, erb_q, is_hi_q, is_lo_q};
          OFS_PC_HI: rdata_d = {3'h0, vec.pc[12:8]};
          OFS_PC_LO: rdata_d = vec.pc[7:0];
          OFS_STATUS: rdata_d = {5'h00, ram.erase_busy, st_q};
          OFS_STACK: rdata_d = sp_q;
          default: begin
            if (ADDR >= OFS_BSC0 && ADDR < OFS_BSC0 + 9'(BSC_N)) begin
              rdata_d = {4'h0, bsc_q[ADDR[1:0]]};
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= DATA_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign RDATA = rdata_q;
  assign PROGRAM_COUNTER = vec.pc;
  assign CPU_RUN = run_q;

  // ==========================================
  // checks
  sequence s_hold;
    st_q == ST_HOLD;
  endsequence

  property p_bank_clr;
    @(posedge REF_CLK) disable iff (!rst_n)
      s_hold |=> (mbank_q == 4'h0 && rbank_q == 4'h0 && bsc_q[0] == 4'h0 && bsc_q[1] == 4'h0
                  && bsc_q[2] == 4'h0 && bsc_q[3] == 4'h0);
  endproperty
  a_bank_clr: assert property (p_bank_clr) else $error("bank or carrier register not cleared");

  property p_irq_clr;
    @(posedge REF_CLK) disable iff (!rst_n) s_hold |=> !is_lo_q && !is_hi_q;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("interrupt status flag not cleared");

  property p_pwr_clr;
    @(posedge REF_CLK) disable iff (!rst_n) s_hold |=> pwr_q == 4'h0;
  endproperty
  a_pwr_clr: assert property (p_pwr_clr) else $error("power control not cleared");

  property p_sstp_clr;
    @(posedge REF_CLK) disable iff (!rst_n) s_hold |=> sstp_q == 4'h0;
  endproperty
  a_sstp_clr: assert property (p_sstp_clr) else $error("subclock stop not cleared");

  property p_clko_clr;
    @(posedge REF_CLK) disable iff (!rst_n) s_hold |=> clko_q == 4'h0;
  endproperty
  a_clko_clr: assert property (p_clko_clr) else $error("clock output mode not cleared");

  property p_sclk_clr;
    @(posedge REF_CLK) disable iff (!rst_n) s_hold |=> sclk_q == 4'h0;
  endproperty
  a_sclk_clr: assert property (p_sclk_clr) else $error("system clock mode not cleared");

  property p_ce_reset;
    @(posedge REF_CLK) disable iff (!rst_n) ce_rise |=> s_hold ##1 !run_q;
  endproperty
  a_ce_reset: assert property (p_ce_reset) else $error("chip enable edge did not reset");
endmodule

// ---- pmem_model.sv ----
`timescale 1ns/1ps
module pmem_model (
  input wire logic clk,
  input wire logic rd,
  input wire logic [12:0] addr,
  input wire logic [7:0] byte0,
  input wire logic [7:0] byte1,
  output logic [7:0] data
);
  logic [7:0] pick;
  initial data = 8'h5a;
  always_comb begin
    pick = (addr == 13'h0000) ? byte0 : ((addr == 13'h0001) ? byte1 : ~data);
  end
  // ==========================================
  // one cycle latency; outside a read the bus toggles so stale data never looks valid
  always @(posedge clk) begin
    if (rd) begin
      data <= pick;
    end else begin
      data <= ~data;
    end
  end
endmodule

// ---- cpu_reset_state_init_tb.sv ----
`timescale 1ns/1ps
module cpu_reset_state_init_tb;
  import rst_init_pkg::*;
  logic REF_CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic RESET_PIN_N = 1'b1;
  logic CE_PIN = 1'b1;
  addr_t ADDR = 9'h000;
  data_t WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  data_t RDATA;
  pc_t PMEM_ADDR;
  logic PMEM_RD;
  data_t PMEM_DATA;
  pc_t PROGRAM_COUNTER;
  logic CPU_RUN;
  logic [7:0] b0 = 8'hc5;
  logic [7:0] b1 = 8'h3a;
  int miscompares = 0;
  int n_checks = 0;
  addr_t clr_ofs [10] = '{9'h000, 9'h001, 9'h002, 9'h003, 9'h004, 9'h005, 9'h00c, 9'h00d, 9'h00e, 9'h00f};
  logic [7:0] ram_a [16];
  logic [3:0] ram_v [16];
  logic [3:0] clr_v [10];
  data_t sp_v;
  always #2.5 REF_CLK = ~REF_CLK;
  cpu_reset_init DUT (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .RESET_PIN_N(RESET_PIN_N), .CE_PIN(CE_PIN),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PMEM_ADDR(PMEM_ADDR),
    .PMEM_RD(PMEM_RD), .PMEM_DATA(PMEM_DATA), .PROGRAM_COUNTER(PROGRAM_COUNTER), .CPU_RUN(CPU_RUN));
  pmem_model ROM (.clk(REF_CLK), .rd(PMEM_RD), .addr(PMEM_ADDR), .byte0(b0), .byte1(b1), .data(PMEM_DATA));
  // ==========================================
  // expectations
  function automatic logic [3:0] ram_after(input logic [7:0] a, input logic [3:0] v);
    return (a >= 8'hf8 && a <= 8'hfd) ? 4'h0 : v;
  endfunction
  function automatic pc_t vec_pc(input logic [7:0] hi, input logic [7:0] lo);
    return {hi[4:0], lo};
  endfunction
  // ==========================================
  // checking and bus tasks
  task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input addr_t a, input data_t d);
    @(posedge REF_CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge REF_CLK);
    WR <= 1'b0;
  endtask
  task automatic rchk(input addr_t a, input data_t exp);
    @(posedge REF_CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge REF_CLK);
    RD <= 1'b0;
    #1;
    chk($sformatf("read %h", a), {5'h00, exp}, {5'h00, RDATA});
  endtask
  task automatic wait_run;
    int i;
    for (i = 0; i < 300 && CPU_RUN !== 1'b1; i++) begin
      @(posedge REF_CLK);
    end
    #1;
    if (CPU_RUN !== 1'b1) begin
      miscompares++;
      $display("unexpected run flag: expected 1, seen %b", CPU_RUN);
      end_sim();
    end
  endtask
  // state every pin reset must leave behind
  task automatic check_reset_state;
    int i;
    chk("program counter", vec_pc(b0, b1), PROGRAM_COUNTER);
    rchk(OFS_PC_HI, {3'b000, b0[4:0]});
    rchk(OFS_PC_LO, b1);
    rchk(OFS_FLAGS, {4'h0, b0[7], b0[6], 2'b00});
    rchk(OFS_STATUS, 8'h03);
    for (i = 0; i < 4; i++) begin
      rchk(clr_ofs[i], DATA_ZERO);
    end
    for (i = 4; i < 10; i++) begin
      rchk(clr_ofs[i], DATA_ZERO);
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    int r;
    int i;
    void'($urandom(44));
    repeat (8) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    wait_run();
    check_reset_state();
    for (i = 8'hf8; i <= 8'hfd; i++) begin
      rchk({1'b1, i[7:0]}, DATA_ZERO);
    end
    rchk(9'h00b, DATA_ZERO);
    for (r = 0; r < 6; r++) begin
      for (i = 0; i < 10; i++) begin
        clr_v[i] = 4'h1 + 4'($urandom % 15);
        wr(clr_ofs[i], {4'h0, clr_v[i]});
      end
      wr(OFS_FLAGS, {4'h0, 4'($urandom)});
      // nonzero values must stick before the reset, else the clear checks prove nothing
      for (i = 0; i < 10; i++) begin
        rchk(clr_ofs[i], {4'h0, clr_v[i]});
      end
      sp_v = 8'($urandom);
      wr(OFS_STACK, sp_v);
      for (i = 0; i < 16; i++) begin
        ram_a[i] = (i < 8) ? 8'(i) : (i < 14) ? 8'(8'hf0 + i) : (i == 14) ? 8'(8'h08 + $urandom % 8'h70)
          : 8'(8'h80 + $urandom % 8'h78);
        ram_v[i] = 4'h1 + 4'($urandom % 15);
        wr({1'b1, ram_a[i]}, {4'h0, ram_v[i]});
      end
      rchk({1'b1, ram_a[15]}, {4'h0, ram_v[15]});
      b0 = (r == 0) ? 8'hff : (r == 1) ? 8'h20 : 8'($urandom);
      b1 = (r == 0) ? 8'h00 : (r == 1) ? 8'hff : 8'($urandom);
      @(posedge REF_CLK);
      if (r % 2 == 1) begin
        CE_PIN <= 1'b0;
        repeat (4) @(posedge REF_CLK);
        CE_PIN <= 1'b1;
        repeat (5) @(posedge REF_CLK);
        #1;
        chk("run after chip enable rise", 13'h0000, {12'h000, CPU_RUN});
      end else begin
        RESET_PIN_N <= 1'b0;
        repeat (4) @(posedge REF_CLK);
        #1;
        chk("run during pin reset", 13'h0000, {12'h000, CPU_RUN});
        wr(OFS_PWR_CTRL, 8'h0f);
        RESET_PIN_N <= 1'b1;
      end
      wait_run();
      check_reset_state();
      for (i = 0; i < 16; i++) begin
        rchk({1'b1, ram_a[i]}, {4'h0, ram_after(ram_a[i], ram_v[i])});
      end
      rchk(OFS_STACK, sp_v);
    end
    end_sim();
  end
endmodule
